// ==== rtl/rpc_pll_config.sv ====
// pll configuration and status registers with axi4-lite slave
`include "rpc_defines.svh"
module rpc_pll_config
   import rpc_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [15:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [15:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // pins and pll status
   input  wire logic        soft_reset_n,
   input  wire logic        pll_lock,
   input  wire logic        strap_mode,
   input  wire logic [1:0]  strap_reference_freq_sel,
   input  wire logic        strap_divider_table_sel,
   // controls to the analog pll
   output logic [3:0]       output_invert_bits,
   output logic             frac_ssc_enable,
   output rpc_nmode_type    n_mode,
   output logic [4:0]       out_buffer_powerdown,
   output logic [3:0]       out5_divide_ratio,
   output logic [1:0]       loop_bandwidth_sel,
   output logic             input_mode,
   output logic [1:0]       reference_freq_sel,
   output logic             divider_table_sel,
   output logic [15:0]      misc_active,
   // interrupt
   output logic             irq
);

   logic [15:0]  cfg3_shadow;
   logic [15:0]  misc_shadow;
   logic [15:0]  cfg3_active;
   logic         lock_lost_sticky;
   logic         force_latch;
   logic [1:0]   irq_status;
   logic [1:0]   irq_mask;
   logic [15:0]  aw_addr;
   logic         aw_held;
   logic [31:0]  w_data;
   logic [3:0]   w_strb;
   logic         w_held;
   logic         wr_fire;
   logic         wr_hit;
   logic [15:0]  wr_val;
   logic [15:0]  rd_val;
   logic         rd_hit;
   logic         srst_level;
   logic         lock_level;
   logic         aw_cfg3;
   logic         aw_misc;
   logic         aw_stat;
   logic         aw_mask;
   logic         ar_cfg3;
   logic         ar_misc;
   logic         ar_stat;
   logic         ar_mask;
   rpc_lock_type lock_state;
   logic         relock_event;
   logic         latch_event;

   // write address and data are taken in either order, response after both
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 16'h0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   // word decode of both address channels; the two byte-lane bits are ignored
   always_comb begin
      aw_cfg3 = ({aw_addr[15:2], 2'b00} == `RPC_ADDR_CFG3);
      aw_misc = ({aw_addr[15:2], 2'b00} == `RPC_ADDR_MISC);
      aw_stat = ({aw_addr[15:2], 2'b00} == `RPC_ADDR_IRQ_STAT);
      aw_mask = ({aw_addr[15:2], 2'b00} == `RPC_ADDR_IRQ_MASK);
      ar_cfg3 = ({s_axi_araddr[15:2], 2'b00} == `RPC_ADDR_CFG3);
      ar_misc = ({s_axi_araddr[15:2], 2'b00} == `RPC_ADDR_MISC);
      ar_stat = ({s_axi_araddr[15:2], 2'b00} == `RPC_ADDR_IRQ_STAT);
      ar_mask = ({s_axi_araddr[15:2], 2'b00} == `RPC_ADDR_IRQ_MASK);
   end

   always_comb begin
      wr_hit = aw_cfg3 || aw_misc || aw_stat || aw_mask;
      wr_val = {w_strb[1] ? w_data[15:8] : 8'h00, w_strb[0] ? w_data[7:0] : 8'h00};
   end

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
                                         input logic [3:0] strb, input logic [15:0] wmask);
      logic [15:0] lane;
      lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
      merge = (old & ~lane) | (val & lane);
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // shadow copies; bit 13 of cfg3 is masked so it stays zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg3_shadow <= `RPC_CFG3_RESET;
         misc_shadow <= `RPC_MISC_RESET;
      end else if (wr_fire) begin
         if (aw_cfg3)
            cfg3_shadow <= merge(cfg3_shadow, wr_val, w_strb, `RPC_CFG3_WMASK);
         if (aw_misc)
            misc_shadow <= merge(misc_shadow, wr_val, w_strb, `RPC_MISC_WMASK);
      end
   end

   // force bit: set by write, cleared by hardware once the latch has happened
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         force_latch <= 1'b0;
      end else if (wr_fire && aw_misc && w_strb[1] && wr_val[`RPC_BIT_FORCE]) begin
         force_latch <= 1'b1;
      end else begin
         force_latch <= 1'b0;
      end
   end

   // soft reset pin starts released so a bus reset alone does not latch
   rpc_sync3 #(
      .RESET_LEVEL (1'b1)
   ) i_srst_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (soft_reset_n),
      .level   (srst_level)
   );

   // lock starts low so the first lock after reset is not taken as a relock
   rpc_sync3 #(
      .RESET_LEVEL (1'b0)
   ) i_lock_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (pll_lock),
      .level   (lock_level)
   );

   // active copies move only on soft reset or a forced latch
   assign latch_event = !srst_level || force_latch;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg3_active <= `RPC_CFG3_RESET;
         misc_active <= `RPC_MISC_RESET;
      end else if (latch_event) begin
         cfg3_active <= cfg3_shadow;
         misc_active <= misc_shadow;
      end
   end

   // lock tracker: relock after a loss raises the sticky flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_state <= RPC_LOCK_WAIT;
      end else begin
         unique case (lock_state)
            RPC_LOCK_WAIT: if (lock_level) lock_state <= RPC_LOCKED;
            RPC_LOCKED:    if (!lock_level) lock_state <= RPC_LOST;
            RPC_LOST:      if (lock_level) lock_state <= RPC_LOCKED;
         endcase
      end
   end

   assign relock_event = (lock_state == RPC_LOST) && lock_level;

   // set wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_lost_sticky <= 1'b0;
      end else if (relock_event) begin
         lock_lost_sticky <= 1'b1;
      end else if (wr_fire && aw_misc && w_strb[1] && wr_val[`RPC_BIT_UNLOCK]) begin
         lock_lost_sticky <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= 2'b00;
         irq_mask   <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == `RPC_IRQ_UNLOCK && relock_event) || (i == `RPC_IRQ_LATCH && latch_event))
               irq_status[i] <= 1'b1;
            else if (wr_fire && aw_stat && w_strb[0] && wr_val[i])
               irq_status[i] <= 1'b0;
         end
         if (wr_fire && aw_mask && w_strb[0])
            irq_mask <= wr_val[1:0];
      end
   end

   assign irq = |(irq_status & irq_mask);

   // read channel: one cycle after arvalid is taken
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rd_hit = 1'b1;
      rd_val = 16'h0000;
      if (ar_cfg3)
         rd_val = cfg3_shadow & `RPC_CFG3_WMASK;
      else if (ar_misc)
         rd_val = {misc_shadow[15], lock_lost_sticky, force_latch, misc_shadow[12:0]};
      else if (ar_stat)
         rd_val = {14'h0000, irq_status};
      else if (ar_mask)
         rd_val = {14'h0000, irq_mask};
      else
         rd_hit = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {16'h0000, rd_val};
         s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // pll control outputs, all from active flops
   always_comb begin
      output_invert_bits   = cfg3_active[12:9];
      loop_bandwidth_sel   = cfg3_active[15:14];
      out_buffer_powerdown = cfg3_active[6:2];
      n_mode = cfg3_active[`RPC_BIT_NMODE] ? RPC_INTEGER_N : RPC_FRAC_SSC;
      // integer mode and the spread bit both disable fractional use
      frac_ssc_enable = !cfg3_active[`RPC_BIT_SSC] && !cfg3_active[`RPC_BIT_NMODE];
   end

   always_comb begin
      unique case (cfg3_active[1:0])
         2'b00: out5_divide_ratio = `RPC_DIV4;
         2'b01: out5_divide_ratio = `RPC_DIV6;
         2'b10: out5_divide_ratio = `RPC_DIV8;
         2'b11: out5_divide_ratio = `RPC_DIV12;
      endcase
   end

   // strap refsel and table pins pass straight through unless software overrides them; the strap mode pin is unused
   always_comb begin
      if (misc_active[`RPC_BIT_OVR]) begin
         input_mode         = misc_active[`RPC_BIT_MODE];
         reference_freq_sel = misc_active[5:4];
         divider_table_sel  = misc_active[`RPC_BIT_TABLE];
      end else begin
         // mode is zero when not overridden
         input_mode         = 1'b0;
         reference_freq_sel = strap_reference_freq_sel;
         divider_table_sel  = strap_divider_table_sel;
      end
   end

   logic unused_strap;
   assign unused_strap = strap_mode;

endmodule

// three-flop pin synchroniser; the level follows once the last two stages agree
module rpc_sync3
   import rpc_pkg::*;
#(
   parameter logic RESET_LEVEL = 1'b0
) (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // raw pin and filtered level
   input  wire logic pin,
   output logic      level
);

   logic [2:0] stages;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stages <= {3{RESET_LEVEL}};
         level  <= RESET_LEVEL;
      end else begin
         stages <= {stages[1:0], pin};
         // a one-cycle disagreement between the last two stages is ignored
         if (stages[2] == stages[1]) begin
            level <= stages[2];
         end
      end
   end

endmodule

// ==== common/rpc_defines.svh ====
// register offsets, field positions, reset values, write masks and divide codes for the pll config block
// What this block does
// - bits 12:9 invert outputs one to four
// - spread bit 1 ignores fractional and spread codes
// - integer mode bit 1 forces integer-N only
// - bits 6:2 power down output buffers five..one
// - bits 1:0 pick divide 4,6,8,12
// - override bit takes mode/refsel/table from register
// - unlock flag sets on relock, write one clears
// - config writes wait in shadow until soft reset
// - force-latch bit applies shadow now, self clears
`ifndef RPC_DEFINES_SVH
`define RPC_DEFINES_SVH
`define RPC_ADDR_CFG3      16'hF98C
`define RPC_ADDR_MISC      16'hF990
`define RPC_ADDR_IRQ_STAT  16'hF994
`define RPC_ADDR_IRQ_MASK  16'hF998
`define RPC_CFG3_RESET     16'h0178
`define RPC_MISC_RESET     16'h0000
`define RPC_CFG3_WMASK     16'hDFFF
`define RPC_MISC_WMASK     16'h9FFF
`define RPC_BIT_RSVD       13
`define RPC_BIT_SSC        8
`define RPC_BIT_NMODE      7
`define RPC_BIT_OVR        15
`define RPC_BIT_UNLOCK     14
`define RPC_BIT_FORCE      13
`define RPC_BIT_TABLE      7
`define RPC_BIT_MODE       3
`define RPC_IRQ_UNLOCK     0
`define RPC_IRQ_LATCH      1
`define RPC_DIV4           4'h4
`define RPC_DIV6           4'h6
`define RPC_DIV8           4'h8
`define RPC_DIV12          4'hC
`endif

// ==== common/rpc_pkg.sv ====
// types for the pll config block
package rpc_pkg;
   typedef enum logic {
      RPC_FRAC_SSC,
      RPC_INTEGER_N
   } rpc_nmode_type;
   typedef enum logic [1:0] {
      RPC_LOCK_WAIT,
      RPC_LOCKED,
      RPC_LOST
   } rpc_lock_type;
endpackage

// ==== testbench/rpc_pll_config_assertions.sv ====
// port-level assertions for the pll config block
`include "rpc_defines.svh"
module rpc_pll_config_assertions
   import rpc_pkg::*;
(
   // clock, bus and pins
   input wire logic        aclk, aresetn, soft_reset_n, s_axi_bvalid, s_axi_bready,
   input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
   input wire logic [15:0] s_axi_araddr, misc_active,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_bresp, s_axi_rresp, reference_freq_sel, strap_reference_freq_sel,
   input wire logic        input_mode, divider_table_sel, strap_divider_table_sel, frac_ssc_enable, irq,
   input wire logic [3:0]  output_invert_bits, out5_divide_ratio,
   input wire logic [4:0]  out_buffer_powerdown,
   input wire rpc_nmode_type n_mode
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [2:0] quiet;
   // margin covers the pin synchroniser and the force load after a write
   always_ff @(posedge aclk) begin
      if (!aresetn || !soft_reset_n || s_axi_bvalid) quiet <= 3'h0;
      else if (quiet != 3'h7) quiet <= quiet + 3'h1;
   end
   a_shadow_hold: assert property (quiet >= 3'h6 |-> $stable({output_invert_bits,
      out_buffer_powerdown, out5_divide_ratio, n_mode, misc_active[15], misc_active[12:0]}))
      else $error("active controls moved without latch");
   a_strap_ref: assert property (reference_freq_sel ==
      (misc_active[15] ? misc_active[5:4] : strap_reference_freq_sel)) else $error("reference select wrong");
   a_strap_table: assert property (divider_table_sel ==
      (misc_active[15] ? misc_active[7] : strap_divider_table_sel)) else $error("table select wrong");
   a_strap_mode: assert property (input_mode ==
      (misc_active[15] & misc_active[`RPC_BIT_MODE])) else $error("input mode wrong");
   a_div_code: assert property (out5_divide_ratio inside
      {`RPC_DIV4, `RPC_DIV6, `RPC_DIV8, `RPC_DIV12}) else $error("divide ratio illegal");
   a_frac_int: assert property (frac_ssc_enable |-> n_mode == RPC_FRAC_SSC)
      else $error("fraction applied in integer mode");
   a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_rdata_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside {`RPC_ADDR_CFG3,
      `RPC_ADDR_MISC, `RPC_ADDR_IRQ_STAT, `RPC_ADDR_IRQ_MASK}) |=> s_axi_rvalid && s_axi_rresp == 2'h2
      && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   c_irq: cover property ($rose(irq));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_override: cover property (misc_active[15] && input_mode);
endmodule
bind rpc_pll_config rpc_pll_config_assertions i_chk (.aclk, .aresetn, .soft_reset_n, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_araddr, .misc_active,
   .s_axi_rdata, .s_axi_bresp, .s_axi_rresp, .reference_freq_sel, .strap_reference_freq_sel, .input_mode,
   .divider_table_sel, .strap_divider_table_sel, .frac_ssc_enable, .irq, .output_invert_bits,
   .out5_divide_ratio, .out_buffer_powerdown, .n_mode);

// ==== testbench/ring_pll_config_regs_tb.sv ====
// self-checking bench for the pll config block
`include "rpc_defines.svh"
module ring_pll_config_regs_tb
   import rpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0;
   logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, soft_reset_n;
   logic pll_lock, strap_mode, strap_divider_table_sel, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, frac_ssc_enable, input_mode, divider_table_sel, irq;
   logic [15:0] s_axi_awaddr, s_axi_araddr, misc_active, v, m, p;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, output_invert_bits, out5_divide_ratio;
   logic [1:0]  s_axi_bresp, s_axi_rresp, strap_reference_freq_sel, loop_bandwidth_sel, reference_freq_sel;
   logic [4:0]  out_buffer_powerdown;
   logic [16:0] pins;
   rpc_nmode_type n_mode;
   int err_count = 0;
   int samples_checked = 0;
   assign pins = {loop_bandwidth_sel, output_invert_bits, frac_ssc_enable, n_mode, out_buffer_powerdown,
                  out5_divide_ratio};
   always #50 aclk = ~aclk;
   rpc_pll_config i_rpc_pll_config (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .soft_reset_n, .pll_lock, .strap_mode, .strap_reference_freq_sel,
      .strap_divider_table_sel, .output_invert_bits, .frac_ssc_enable, .n_mode, .out_buffer_powerdown,
      .out5_divide_ratio, .loop_bandwidth_sel, .input_mode, .reference_freq_sel, .divider_table_sel,
      .misc_active, .irq);
   task automatic final_report();
      $display("mismatches %0d comparisons %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // expected pll controls from a config three word
   function automatic logic [16:0] dec(input logic [15:0] c);
      logic [3:0] dv;
      dv = (c[1:0] == 2'h0) ? 4'h4 : (c[1:0] == 2'h1) ? 4'h6 : (c[1:0] == 2'h2) ? 4'h8 : 4'hC;
      return {c[15:14], c[12:9], ~c[8] & ~c[7], c[7], c[6:2], dv};
   endfunction
   task automatic wr(input logic [15:0] a, input logic [31:0] x, input logic [1:0] er);
      logic ta, tw;
      {ta, tw} = 2'h0;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, x, 3'h7};
      // ready is combinational, so it is sampled mid-cycle to dodge the edge race
      while (!(ta && tw)) begin
         @(negedge aclk);
         ta = ta | (s_axi_awready & s_axi_awvalid);
         tw = tw | (s_axi_wready & s_axi_wvalid);
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      chk(s_axi_bresp, er);
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 68'hF;
      {soft_reset_n, pll_lock, strap_mode} = 3'h6;
      void'($urandom(32'hAA61));
      {strap_reference_freq_sel, strap_divider_table_sel} = 3'($urandom);
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`RPC_ADDR_CFG3, 32'h0178, 2'h0);
      rd(`RPC_ADDR_MISC, 32'h0, 2'h0);
      chk(pins, dec(16'h0178));
      chk({input_mode, reference_freq_sel, divider_table_sel}, {1'b0, strap_reference_freq_sel,
          strap_divider_table_sel});
      p = 16'h0178;
      for (int i = 0; i < 8; i++) begin
         v = 16'($urandom);
         v[1:0] = i[1:0];
         v[8:7] = i[2:1];
         wr(`RPC_ADDR_CFG3, {16'h0, v}, 2'h0);
         chk(pins, dec(p));
         rd(`RPC_ADDR_CFG3, {16'h0, v & 16'hDFFF}, 2'h0);
         @(posedge aclk);
         soft_reset_n <= 1'b0;
         repeat (6) @(posedge aclk);
         soft_reset_n <= 1'b1;
         repeat (6) @(posedge aclk);
         chk(pins, dec(v));
         p = v;
      end
      chk(irq, 1'b0);
      rd(`RPC_ADDR_IRQ_STAT, 32'h2, 2'h0);
      wr(`RPC_ADDR_IRQ_MASK, 32'h3, 2'h0);
      chk(irq, 1'b1);
      wr(`RPC_ADDR_IRQ_STAT, 32'h3, 2'h0);
      wr(`RPC_ADDR_IRQ_MASK, 32'h0, 2'h0);
      rd(`RPC_ADDR_IRQ_STAT, 32'h0, 2'h0);
      v = 16'($urandom);
      m = (16'($urandom) & 16'h1FFF) | 16'hA000;
      wr(`RPC_ADDR_CFG3, {16'h0, v}, 2'h0);
      wr(`RPC_ADDR_MISC, {16'h0, m}, 2'h0);
      repeat (4) @(negedge aclk);
      chk(pins, dec(v));
      chk({input_mode, reference_freq_sel, divider_table_sel}, {m[3], m[5:4], m[7]});
      chk(misc_active, m & 16'h9FFF);
      rd(`RPC_ADDR_MISC, {16'h0, m & 16'h9FFF}, 2'h0);
      wr(`RPC_ADDR_IRQ_STAT, 32'h3, 2'h0);
      wr(`RPC_ADDR_IRQ_MASK, 32'h1, 2'h0);
      chk(irq, 1'b0);
      @(posedge aclk);
      pll_lock <= 1'b0;
      repeat (8) @(posedge aclk);
      pll_lock <= 1'b1;
      repeat (8) @(posedge aclk);
      chk(irq, 1'b1);
      rd(`RPC_ADDR_IRQ_STAT, 32'h1, 2'h0);
      rd(`RPC_ADDR_MISC, {16'h0, (m & 16'h9FFF) | 16'h4000}, 2'h0);
      wr(`RPC_ADDR_MISC, {16'h0, (m & 16'h9FFF) | 16'h4000}, 2'h0);
      rd(`RPC_ADDR_MISC, {16'h0, m & 16'h9FFF}, 2'h0);
      wr(`RPC_ADDR_IRQ_STAT, 32'h1, 2'h0);
      chk(irq, 1'b0);
      wr(16'hF9A0, 32'h5, 2'h2);
      rd(16'hF9A0, 32'h0, 2'h2);
      final_report();
   end
   initial begin
      #200000;
      err_count++;
      final_report();
   end
endmodule
